// >>> timer_lp_consts.svh
// Offsets, field positions, reset values and timing counts of the timer and low-power block
`ifndef TIMER_LP_CONSTS_SVH
`define TIMER_LP_CONSTS_SVH
// ==========================================================
// Register map
`define TLP_ADDR_CTRL      8'h09
`define TLP_ADDR_COUNT     8'h08
`define TLP_CTRL_RESET     8'h40
`define TLP_COUNT_RESET    8'hff
`define TLP_COUNT_ONE      8'h01
`define TLP_COUNT_ZERO     8'h00
// ==========================================================
// Control field positions
`define TLP_BIT_REQ        7
`define TLP_BIT_INHIBIT    6
`define TLP_BIT_SRC        5
`define TLP_BIT_EXT_EN     4
`define TLP_BIT_PCLR       3
`define TLP_SEL_HI         2
`define TLP_SEL_LO         0
// ==========================================================
// Instruction cycle: oscillator periods per cycle
`define TLP_OSC_PER_CYC    5
`define TLP_CYC_CNT_W      3
// ==========================================================
// Interrupt vectors
`define TLP_VEC_TIMER      13'h1ff8
`define TLP_VEC_TIMER_WAIT 13'h1ff6
`define TLP_VEC_EXT        13'h1ffa
`define TLP_VEC_NONE       13'h0000
`endif

// >>> timer_lp_pkg.sv
// Types shared by the timer and low-power block
package timer_lp_pkg;
   typedef enum logic [1:0] {PS_RUN, PS_STOP, PS_WAIT} power_state_e;
   typedef logic [12:0] vec_addr_t;
endpackage

// >>> pin_sync.sv
// Two-flop pin synchroniser with falling-edge pulse
`timescale 1ns/10ps
module pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic pin,
   output logic      level,
   output logic      fall
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // Only sync_q reads meta_q; edge logic looks at later stages
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= RESET_LEVEL;
         sync_q <= RESET_LEVEL;
         last_q <= RESET_LEVEL;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign fall  = last_q & ~sync_q;
endmodule

// >>> tap_prescaler.sv
// Binary prescaler with a power-of-two output tap
`timescale 1ns/10ps
module tap_prescaler #(
   parameter int WIDTH = 7,
   parameter int SEL_W = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             tick,
   input  wire logic             clear,
   input  wire logic [SEL_W-1:0] sel,
   output logic                  tap
);
   logic [WIDTH-1:0] presc_q;
   logic [WIDTH-1:0] presc_d;
   logic [WIDTH:0]   low_mask;
   logic             low_full;

   // Tap fires on the tick that carries the low sel bits out
   assign low_mask = (WIDTH+1)'((1 << sel) - 1);
   assign low_full = ((presc_q & low_mask[WIDTH-1:0]) == low_mask[WIDTH-1:0]);
   assign tap      = tick & low_full;
   assign presc_d  = clear ? '0 : (tick ? presc_q + 1'b1 : presc_q);

   // Counts selected source ticks, not readable from outside
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         presc_q <= '0;
      end else begin
         presc_q <= presc_d;
      end
   end

   chk_clear_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clear |=> presc_q == '0) else $error("prescaler not cleared");
endmodule

// >>> timer_lp.sv
// Timer, prescaler, control register and stop/wait control
`timescale 1ns/10ps
`include "timer_lp_consts.svh"

// Operation
// - Stop sets timer inhibit bit and clears the timer request bit.
// - Low power drives data and address strobes low, read/write-low high.
// - Low power turns bus to input and holds next instruction address.
// - Stop clears I bit; only external interrupt or reset ends stop.
// - Wait clears I bit; external, timer interrupt or reset ends wait.
// - External wins over timer in wait; later timer uses normal vector.
// - Eight-bit down-counter after seven-bit prescaler sets request on reaching zero.
// - Unmasked request interrupts; timer vector, or wait vector during wait.
// - Power-on reset loads counter with all ones.
// - Prescaler and counter advance on falling edge of selected source.
// - Counter write takes effect during data strobe; otherwise counts continuously.
// - Counter wraps from zero to all ones and keeps counting.
// - Reading the count returns current value without disturbing counting.
// - Request bit stays set until software clears it; clearing cancels.
// - Writing one to bit 3 clears prescaler; bit reads zero.
// - Bits 4,5 zero: internal cycle clock, pin ignored.
// - Bit 4 set, 5 clear: internal clock ANDed with timer pin.
// - Bit 4 clear, 5 set: all count inputs blocked.
// - Bits 4,5 set: counter driven by timer pin only.
// - In wait the internal timer clock keeps running at normal rate.
// - Reset clears request bit, sets inhibit bit, leaves bits 5-0.
// - Select bits choose prescaler tap dividing by two to the select.
module timer_lp #(
   parameter int ADDR_HI_W = 5,
   parameter int PRESC_W   = 7
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_b,
   input  wire logic                  core_reset,
   input  wire logic [7:0]            reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata,
   input  wire logic                  stop_exec,
   input  wire logic                  wait_exec,
   input  wire logic                  cc_i_mask,
   input  wire logic                  irq_ack,
   output logic                       cc_i_clear,
   input  wire logic                  ext_irq_pin_b,
   input  wire logic                  timer_pin,
   input  wire logic                  core_as,
   input  wire logic                  core_ds,
   input  wire logic                  core_rw_b,
   input  wire logic [ADDR_HI_W-1:0]  next_addr_hi,
   output logic                       address_strobe,
   output logic                       data_strobe,
   output logic                       rw_b,
   output logic                       bus_dir_in,
   output logic      [ADDR_HI_W-1:0]  addr_hi_out,
   output timer_lp_pkg::power_state_e power_state,
   output logic                       timer_irq,
   output logic                       ext_irq,
   output timer_lp_pkg::vec_addr_t    irq_vector
);
   import timer_lp_pkg::*;

   // ==========================================================
   // State
   power_state_e              state_q;
   power_state_e              state_d;
   logic [7:0]                ctrl_q;
   logic [7:0]                ctrl_d;
   logic [7:0]                count_q;
   logic [7:0]                count_d;
   logic [`TLP_CYC_CNT_W-1:0] cyc_q;
   logic [ADDR_HI_W-1:0]      addr_hold_q;
   logic                      wait_vec_q;
   logic                      wait_vec_d;
   logic                      i_clear_q;
   logic [7:0]                rdata_q;
   vec_addr_t                 vector_q;
   vec_addr_t                 vector_d;

   // ==========================================================
   // Decode and pins
   logic       ext_b_lvl;
   logic       pin_lvl;
   logic       pin_fall;
   logic       wr_ctrl;
   logic       wr_count;
   logic       rd_ctrl;
   logic       rd_count;
   logic       low_power;
   logic       enter_stop;
   logic       enter_wait;
   logic       ext_pend;
   logic       timer_pend;
   logic       int_fall;
   logic       src_sel;
   logic       ext_en;
   logic       count_tick;
   logic       tap;
   logic       zero_hit;
   logic       presc_clear;
   logic       leave_wait;
   logic       wait_vec_any;
   logic [7:0] ctrl_view;

   pin_sync #(.RESET_LEVEL(1'b1)) u_ext_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .pin     (ext_irq_pin_b),
      .level   (ext_b_lvl),
      .fall    ()
   );

   pin_sync #(.RESET_LEVEL(1'b0)) u_pin_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .pin     (timer_pin),
      .level   (pin_lvl),
      .fall    (pin_fall)
   );

   // Register strobes; the core qualifies writes with its data strobe
   assign wr_ctrl  = reg_wr && (reg_addr == `TLP_ADDR_CTRL);
   assign wr_count = reg_wr && (reg_addr == `TLP_ADDR_COUNT);
   assign rd_ctrl  = reg_rd && (reg_addr == `TLP_ADDR_CTRL);
   assign rd_count = reg_rd && (reg_addr == `TLP_ADDR_COUNT);

   // Power state terms
   assign low_power  = (state_q != PS_RUN);
   assign enter_stop = (state_q == PS_RUN) && stop_exec && !core_reset;
   assign enter_wait = (state_q == PS_RUN) && wait_exec && !stop_exec && !core_reset;
   assign ext_pend   = !ext_b_lvl;
   assign timer_pend = ctrl_q[`TLP_BIT_REQ] && !ctrl_q[`TLP_BIT_INHIBIT];
   assign leave_wait = (state_q == PS_WAIT) && (ext_pend || timer_pend);

   // ==========================================================
   // Instruction cycle divider, runs in wait as well
   assign int_fall = (cyc_q == `TLP_CYC_CNT_W'(`TLP_OSC_PER_CYC - 1));

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cyc_q <= '0;
      end else if (int_fall || state_q == PS_STOP) begin
         cyc_q <= '0;
      end else begin
         cyc_q <= cyc_q + 1'b1;
      end
   end

   // ==========================================================
   // Count source selection
   assign src_sel    = ctrl_q[`TLP_BIT_SRC];
   assign ext_en     = ctrl_q[`TLP_BIT_EXT_EN];
   assign count_tick = (state_q != PS_STOP) &&
                       ((!src_sel && !ext_en && int_fall) ||
                        (!src_sel && ext_en && int_fall && pin_lvl) ||
                        (src_sel && ext_en && pin_fall));
   assign presc_clear = wr_ctrl && reg_wdata[`TLP_BIT_PCLR];

   tap_prescaler #(.WIDTH(PRESC_W), .SEL_W(3)) u_presc (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .tick    (count_tick),
      .clear   (presc_clear),
      .sel     (ctrl_q[`TLP_SEL_HI:`TLP_SEL_LO]),
      .tap     (tap)
   );

   // ==========================================================
   // Counter: write wins over a decrement, wraps past zero
   assign zero_hit = tap && !wr_count && (count_q == `TLP_COUNT_ONE);
   assign count_d  = wr_count ? reg_wdata :
                     (tap ? count_q - 8'h01 : count_q);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= `TLP_COUNT_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   // ==========================================================
   // Control register next value
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = reg_wdata;
         ctrl_d[`TLP_BIT_PCLR] = 1'b0;
      end
      if (zero_hit) begin
         ctrl_d[`TLP_BIT_REQ] = 1'b1;
      end
      if (enter_stop) begin
         ctrl_d[`TLP_BIT_REQ]     = 1'b0;
         ctrl_d[`TLP_BIT_INHIBIT] = 1'b1;
      end
      if (core_reset) begin
         ctrl_d[`TLP_BIT_REQ]     = 1'b0;
         ctrl_d[`TLP_BIT_INHIBIT] = 1'b1;
      end
   end

   // Power-on reset gives the full reset value; core reset leaves bits 5-0
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= `TLP_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ==========================================================
   // Power state machine
   always_comb begin
      state_d = state_q;
      case (state_q)
         PS_RUN: begin
            if (enter_stop) begin
               state_d = PS_STOP;
            end else if (enter_wait) begin
               state_d = PS_WAIT;
            end
         end
         PS_STOP: begin
            if (ext_pend) begin
               state_d = PS_RUN;
            end
         end
         PS_WAIT: begin
            if (leave_wait) begin
               state_d = PS_RUN;
            end
         end
         default: state_d = PS_RUN;
      endcase
      if (core_reset) begin
         state_d = PS_RUN;
      end
   end

   // Wait vector only when the timer alone ends the wait
   assign wait_vec_d = (core_reset || irq_ack) ? 1'b0 :
                       ((leave_wait && !ext_pend) ? 1'b1 : wait_vec_q);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= PS_RUN;
         wait_vec_q <= 1'b0;
         i_clear_q  <= 1'b0;
      end else begin
         state_q    <= state_d;
         wait_vec_q <= wait_vec_d;
         i_clear_q  <= enter_stop || enter_wait;
      end
   end

   // Next instruction address captured on entry to low power
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         addr_hold_q <= '0;
      end else if (!low_power) begin
         addr_hold_q <= next_addr_hi;
      end
   end

   // ==========================================================
   // Interrupt requests and vector, external first
   assign timer_irq = timer_pend && !cc_i_mask;
   assign ext_irq   = ext_pend && !cc_i_mask;
   // Wait vector already in the cycle the timer ends the wait, not one cycle late
   assign wait_vec_any = wait_vec_q || (leave_wait && !ext_pend);
   assign vector_d  = ext_irq ? `TLP_VEC_EXT :
                      (timer_irq ? (wait_vec_any ? `TLP_VEC_TIMER_WAIT : `TLP_VEC_TIMER)
                                 : `TLP_VEC_NONE);

   // Read view: prescaler clear reads zero
   assign ctrl_view = {ctrl_q[7:4], 1'b0, ctrl_q[2:0]};

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q  <= '0;
         vector_q <= `TLP_VEC_NONE;
      end else begin
         vector_q <= vector_d;
         if (rd_ctrl) begin
            rdata_q <= ctrl_view;
         end else if (rd_count) begin
            rdata_q <= count_q;
         end else if (reg_rd) begin
            rdata_q <= '0;
         end
      end
   end

   // ==========================================================
   // Outputs; low power forces strobes and bus direction
   assign address_strobe = low_power ? 1'b0 : core_as;
   assign data_strobe    = low_power ? 1'b0 : core_ds;
   assign rw_b           = low_power ? 1'b1 : core_rw_b;
   assign bus_dir_in     = low_power;
   assign addr_hi_out    = low_power ? addr_hold_q : next_addr_hi;
   assign cc_i_clear     = i_clear_q;
   assign reg_rdata      = rdata_q;
   assign irq_vector     = vector_q;
   assign power_state    = state_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   chk_stop_flags: assert property (enter_stop && !core_reset |=>
      ctrl_q[`TLP_BIT_INHIBIT] && !ctrl_q[`TLP_BIT_REQ]) else $error("stop flags wrong");
   chk_lp_strobes: assert property (state_q != PS_RUN |->
      !address_strobe && !data_strobe && rw_b) else $error("strobes active in low power");
   chk_addr_hold: assert property (low_power && $past(low_power) |->
      bus_dir_in && $stable(addr_hi_out)) else $error("address not held");
   chk_stop_stays: assert property (state_q == PS_STOP && ext_b_lvl && !core_reset |=>
      state_q == PS_STOP) else $error("stop left without cause");
   chk_i_clear: assert property ((enter_stop || enter_wait) |=>
      cc_i_clear ##1 !cc_i_clear) else $error("I bit clear pulse wrong");
   chk_ext_first: assert property (ext_pend && !cc_i_mask |=>
      irq_vector == `TLP_VEC_EXT) else $error("external not first");
   chk_zero_req: assert property (zero_hit && !enter_stop && !core_reset |=>
      ctrl_q[`TLP_BIT_REQ]) else $error("request not set at zero");
   chk_req_sticky: assert property (ctrl_q[`TLP_BIT_REQ] && !wr_ctrl && !enter_stop &&
      !core_reset |=> ctrl_q[`TLP_BIT_REQ]) else $error("request dropped");
   chk_wrap_ff: assert property (tap && !wr_count && count_q == `TLP_COUNT_ZERO |=>
      count_q == `TLP_COUNT_RESET) else $error("no wrap");
   chk_read_count: assert property (rd_count |=>
      reg_rdata == $past(count_q)) else $error("count read wrong");
   chk_blocked_mode: assert property (src_sel && !ext_en |=>
      $stable(count_q) || $past(wr_count)) else $error("counter moved while blocked");
   chk_stop_frozen: assert property (state_q == PS_STOP && !wr_count |=>
      $stable(count_q)) else $error("counter moved in stop");
   chk_wait_vec: assert property (state_q == PS_WAIT && timer_irq && !ext_pend |=>
      irq_vector == `TLP_VEC_TIMER_WAIT) else $error("wait vector not used");

   cov_stop_exit: cover property (state_q == PS_STOP ##1 state_q == PS_RUN);
   cov_wait_timer: cover property (leave_wait && !ext_pend ##1 wait_vec_q);
   cov_wrap: cover property (tap && count_q == `TLP_COUNT_ZERO);
   cov_ext_mode: cover property (src_sel && ext_en && pin_fall);
endmodule

// >>> core_model.sv
// Behavioural core facing the timer block: strobes, fetch address, I bit and vector taking
`timescale 1ns/10ps
module core_model (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire logic                    cc_i_clear,
   input  wire logic                    cli,
   input  wire timer_lp_pkg::vec_addr_t irq_vector,
   output logic                         cc_i_mask,
   output logic                         irq_ack,
   output logic                         core_as,
   output logic                         core_ds,
   output logic                         core_rw_b,
   output logic [4:0]                   next_addr_hi
);
   import timer_lp_pkg::*;
   // ==========================================================
   // Busy core: strobes and fetch address change every cycle, so a held value shows
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {core_as, core_ds, core_rw_b, next_addr_hi} <= 8'h00;
      end else begin
         {core_as, core_ds, core_rw_b, next_addr_hi} <= 8'($urandom);
      end
   end
   // I bit: set when a vector is taken, cleared on request or held clear by the bench
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cc_i_mask <= 1'b0;
         irq_ack   <= 1'b0;
      end else begin
         irq_ack   <= (irq_vector != 13'h0000) && !cc_i_mask && !irq_ack;
         cc_i_mask <= (cc_i_clear || cli) ? 1'b0 : (cc_i_mask || irq_ack);
      end
   end
endmodule

// >>> tb.sv
// Self-checking bench for the timer and low-power block
`timescale 1ns/10ps
`include "timer_lp_consts.svh"
module tb;
   import timer_lp_pkg::*;
   logic         clk_sys, rst_b, core_reset, reg_wr, reg_rd, stop_exec, wait_exec, cli;
   logic         cc_i_mask, irq_ack, cc_i_clear, ext_irq_pin_b, timer_pin, rd_seen;
   logic         core_as, core_ds, core_rw_b, address_strobe, data_strobe, rw_b, bus_dir_in;
   logic         timer_irq, ext_irq;
   logic [7:0]   reg_addr, reg_wdata, reg_rdata;
   logic [7:0]   exp_q[$];
   logic [4:0]   next_addr_hi, addr_hi_out, held;
   power_state_e power_state;
   vec_addr_t    irq_vector;
   int           n_errors, num_checks, i;
   realtime      t0;

   timer_lp u_timer_lp (.clk_sys(clk_sys), .rst_b(rst_b), .core_reset(core_reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .stop_exec(stop_exec), .wait_exec(wait_exec),
      .cc_i_mask(cc_i_mask), .irq_ack(irq_ack), .cc_i_clear(cc_i_clear),
      .ext_irq_pin_b(ext_irq_pin_b), .timer_pin(timer_pin), .core_as(core_as),
      .core_ds(core_ds), .core_rw_b(core_rw_b), .next_addr_hi(next_addr_hi),
      .address_strobe(address_strobe), .data_strobe(data_strobe), .rw_b(rw_b),
      .bus_dir_in(bus_dir_in), .addr_hi_out(addr_hi_out), .power_state(power_state),
      .timer_irq(timer_irq), .ext_irq(ext_irq), .irq_vector(irq_vector));
   core_model u_core_model (.clk_sys(clk_sys), .rst_b(rst_b), .cc_i_clear(cc_i_clear),
      .cli(cli), .irq_vector(irq_vector), .cc_i_mask(cc_i_mask), .irq_ack(irq_ack),
      .core_as(core_as), .core_ds(core_ds), .core_rw_b(core_rw_b),
      .next_addr_hi(next_addr_hi));

   // ==========================================================
   // Clock and shared tasks
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic check(input string name, input logic [15:0] e, input logic [15:0] got);
      num_checks++;
      if (got !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, e, got);
      end
   endtask
   // One bus cycle from a falling edge; signals stand until the next call
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(negedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d);
      op(1'b0, 1'b0, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      op(1'b0, 1'b1, a, 8'h00);
      op(1'b0, 1'b0, a, 8'h00);
   endtask
   // Low-power pins the cycle after entry
   task automatic lp_enter(input logic is_stop, input power_state_e st);
      stop_exec <= is_stop;
      wait_exec <= !is_stop;
      @(negedge clk_sys);
      stop_exec <= 1'b0;
      wait_exec <= 1'b0;
      check("power_state", 16'(st), 16'(power_state));
      check("strobes", 16'h0003, {12'h0, address_strobe, data_strobe, rw_b, bus_dir_in});
      check("cc_i_clear", 16'h0001, {15'h0, cc_i_clear});
   endtask
   task automatic wait_vec(input int lim);
      for (i = 0; i < lim && irq_vector === `TLP_VEC_NONE; i++) @(negedge clk_sys);
   endtask
   task automatic wrap_up();
      $display("checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Read results are compared the cycle after the read is taken
   always @(posedge clk_sys) rd_seen <= reg_rd;
   always @(negedge clk_sys) begin
      if (rd_seen === 1'b1 && exp_q.size() > 0) begin
         check("reg_rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
      end
   end
   // Watchdog at about five times the expected length of the run
   initial begin
      #60000;
      n_errors++;
      wrap_up();
   end

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(99617));
      {rst_b, core_reset, reg_wr, reg_rd, stop_exec, wait_exec, cli, timer_pin} = 8'h00;
      {ext_irq_pin_b, reg_addr, reg_wdata} = 17'h10000;
      n_errors = 0;
      num_checks = 0;
      repeat (4) @(negedge clk_sys);
      rst_b <= 1'b1;
      @(negedge clk_sys);
      // Reset values; a core reset keeps the low control bits
      rd(`TLP_ADDR_CTRL, `TLP_CTRL_RESET);
      rd(`TLP_ADDR_COUNT, `TLP_COUNT_RESET);
      wr(`TLP_ADDR_CTRL, 8'ha5);
      core_reset <= 1'b1;
      @(negedge clk_sys);
      core_reset <= 1'b0;
      rd(`TLP_ADDR_CTRL, 8'h65);
      rd(8'h0c, 8'h00);
      // Pin-driven counting with a wrap past zero
      wr(`TLP_ADDR_CTRL, 8'h38);
      rd(`TLP_ADDR_CTRL, 8'h30);
      wr(`TLP_ADDR_COUNT, 8'h02);
      repeat (3) begin
         timer_pin <= 1'b1;
         repeat (4) @(negedge clk_sys);
         timer_pin <= 1'b0;
         repeat (4) @(negedge clk_sys);
      end
      rd(`TLP_ADDR_COUNT, 8'hff);
      rd(`TLP_ADDR_CTRL, 8'hb0);
      // Blocked source, then gated source with the pin low
      wr(`TLP_ADDR_CTRL, 8'h20);
      repeat (40) begin
         timer_pin <= 1'($urandom);
         @(negedge clk_sys);
      end
      rd(`TLP_ADDR_COUNT, 8'hff);
      timer_pin <= 1'b0;
      repeat (4) @(negedge clk_sys);
      wr(`TLP_ADDR_CTRL, 8'h10);
      repeat (40) @(negedge clk_sys);
      rd(`TLP_ADDR_COUNT, 8'hff);
      // Time between two expiries for every prescaler select value
      cli <= 1'b1;
      for (int s = 0; s < 8; s++) begin
         wr(`TLP_ADDR_CTRL, 8'h08 | 8'(s));
         wr(`TLP_ADDR_COUNT, 8'h01);
         for (i = 0; i < 2000 && timer_irq !== 1'b1; i++) @(negedge clk_sys);
         t0 = $realtime;
         wr(`TLP_ADDR_CTRL, 8'(s));
         wr(`TLP_ADDR_COUNT, 8'h01);
         for (i = 0; i < 2000 && timer_irq !== 1'b1; i++) begin
            timer_pin <= 1'($urandom);
            @(negedge clk_sys);
         end
         check("tap period", 16'(5 << s), 16'(int'(($realtime - t0) / 4.0)));
      end
      cli <= 1'b0;
      // Stop: request dropped, inhibit set, address held, left only by the pin
      wr(`TLP_ADDR_CTRL, 8'ha0);
      lp_enter(1'b1, PS_STOP);
      held = addr_hi_out;
      repeat (20) @(negedge clk_sys);
      check("addr_hi_out", 16'(held), 16'(addr_hi_out));
      check("power_state", 16'(PS_STOP), 16'(power_state));
      rd(`TLP_ADDR_CTRL, 8'h60);
      ext_irq_pin_b <= 1'b0;
      wait_vec(10);
      check("power_state", 16'(PS_RUN), 16'(power_state));
      check("irq_vector", 16'(`TLP_VEC_EXT), 16'(irq_vector));
      check("ext_irq", 16'h0001, {15'h0, ext_irq});
      ext_irq_pin_b <= 1'b1;
      // Wait: the timer keeps running and ends wait with the wait vector
      wr(`TLP_ADDR_CTRL, 8'h00);
      wr(`TLP_ADDR_COUNT, 8'h03);
      lp_enter(1'b0, PS_WAIT);
      wait_vec(100);
      check("power_state", 16'(PS_RUN), 16'(power_state));
      check("irq_vector", 16'(`TLP_VEC_TIMER_WAIT), 16'(irq_vector));
      check("timer_irq", 16'h0001, {15'h0, timer_irq});
      wr(`TLP_ADDR_CTRL, 8'h20);
      // Timer request inhibited in wait: external ends it, the timer then takes its normal vector
      wr(`TLP_ADDR_CTRL, 8'he0);
      lp_enter(1'b0, PS_WAIT);
      repeat (20) @(negedge clk_sys);
      check("power_state", 16'(PS_WAIT), 16'(power_state));
      ext_irq_pin_b <= 1'b0;
      wait_vec(10);
      check("irq_vector", 16'(`TLP_VEC_EXT), 16'(irq_vector));
      ext_irq_pin_b <= 1'b1;
      repeat (6) @(negedge clk_sys);
      wr(`TLP_ADDR_CTRL, 8'ha0);
      cli <= 1'b1;
      wait_vec(10);
      check("irq_vector", 16'(`TLP_VEC_TIMER), 16'(irq_vector));
      cli <= 1'b0;
      wr(`TLP_ADDR_CTRL, 8'h20);
      rd(`TLP_ADDR_CTRL, 8'h20);
      wrap_up();
   end
endmodule
